/* File: include/cfr_defines.vh */
`ifndef CFR_DEFINES_VH
`define CFR_DEFINES_VH

// ==========================================================
// register offsets
`define CFR_ADDR_MISC 8'h07
`define CFR_ADDR_STATUS 8'h08
`define CFR_ADDR_FAULT 8'h09

// ==========================================================
// reset values
`define CFR_MISC_RESET 8'h4b
`define CFR_FAULT_RESET 8'h00
`define CFR_UNMAPPED_DATA 8'h00

// ==========================================================
// misc control fields
`define CFR_MISC_DETECT 7
`define CFR_MISC_SLOWDOWN 6
`define CFR_MISC_BATOFF 5
`define CFR_MISC_CHG_INT 1
`define CFR_MISC_BAT_INT 0

// ==========================================================
// fault register fields
`define CFR_FLT_WDOG 7
`define CFR_FLT_BOOST 6
`define CFR_FLT_CODE_HI 5
`define CFR_FLT_CODE_LO 4
`define CFR_FLT_BATOV 3
`define CFR_FLT_COLD 1
`define CFR_FLT_HOT 0
`define CFR_FLT_SINGLE_MASK 8'hcb

// ==========================================================
// charge fault codes
`define CFR_CF_NORMAL 2'h0
`define CFR_CF_INPUT 2'h1

`endif

/* File: logic/cfr_fault_latch.v */
`timescale 1ns/1ns
`include "cfr_defines.vh"

module cfr_fault_latch
(
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // live fault conditions
    input wire [7:0] fault_live,
    input wire adapter_removed,
    // control
    input wire fault_clear,
    input wire chg_int_en,
    input wire bat_int_en,
    // results
    output reg [7:0] fault_r,
    output reg fault_irq_r
);

// ==========================================================
// event composition
reg [7:0] ev;
reg [7:0] base;
reg [7:0] fault_nxt;
reg [7:0] fresh;
reg code_new;
reg irq_nxt;

always @*
begin
    ev = fault_live;
    if (adapter_removed && fault_live[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] == `CFR_CF_NORMAL)
    begin
        ev[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] = `CFR_CF_INPUT;
    end
    base = fault_clear ? `CFR_FAULT_RESET : fault_r;
    fault_nxt = (base | ev) & `CFR_FLT_SINGLE_MASK;
    if (base[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] == `CFR_CF_NORMAL)
    begin
        fault_nxt[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] = ev[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO];
    end
    else
    begin
        fault_nxt[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] = base[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO];
    end
    fresh = fault_nxt & ~base;
    code_new = (base[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] == `CFR_CF_NORMAL) &&
               (ev[`CFR_FLT_CODE_HI:`CFR_FLT_CODE_LO] != `CFR_CF_NORMAL);
    irq_nxt = fresh[`CFR_FLT_WDOG] | fresh[`CFR_FLT_BOOST] | fresh[`CFR_FLT_COLD] | fresh[`CFR_FLT_HOT] |
              (code_new & chg_int_en) |
              (fresh[`CFR_FLT_BATOV] & bat_int_en);
end

// ==========================================================
// latch and interrupt pulse
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        fault_r <= `CFR_FAULT_RESET;
        fault_irq_r <= 1'b0;
    end
    else
    begin
        fault_r <= fault_nxt;
        fault_irq_r <= irq_nxt;
    end
end

endmodule

/* File: logic/cfr_ctrl_regs.v */
`timescale 1ns/1ns
`include "cfr_defines.vh"

module cfr_ctrl_regs
#(
    parameter [6:0] DEV_ADDR = 7'h50
)
(
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // two-wire host port
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    // control outputs
    output wire port_detect_request,
    output reg port_detect_active,
    output reg timer_half_speed,
    output wire battery_switch_off,
    // detection
    input wire input_power_present,
    input wire port_detect_done,
    // live status
    input wire [1:0] input_source_status,
    input wire [1:0] charge_phase_status,
    input wire input_voltage_regulation,
    input wire input_current_regulation,
    input wire input_good_status,
    input wire thermal_reg_status,
    input wire min_sys_reg_status,
    // fault conditions
    input wire watchdog_expired,
    input wire boost_fault,
    input wire [1:0] charge_fault_code,
    input wire battery_overvoltage_fault,
    input wire boost_mode,
    input wire cold_buck,
    input wire cold_boost,
    input wire hot_buck,
    input wire hot_boost,
    input wire adapter_removed,
    // interrupt
    output wire fault_irq
);

// ==========================================================
// reset release
reg rst_a_r;
reg rst_n_r;

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        rst_a_r <= 1'b0;
        rst_n_r <= 1'b0;
    end
    else
    begin
        rst_a_r <= 1'b1;
        rst_n_r <= rst_a_r;
    end
end

// ==========================================================
// register read mux
function [7:0] rd_mux;
    input [7:0] addr;
    input [7:0] misc;
    input [7:0] stat;
    input [7:0] flt;
    begin
        case (addr)
            `CFR_ADDR_MISC: rd_mux = misc;
            `CFR_ADDR_STATUS: rd_mux = stat;
            `CFR_ADDR_FAULT: rd_mux = flt;
            default: rd_mux = `CFR_UNMAPPED_DATA;
        endcase
    end
endfunction

// ==========================================================
// status and fault sources
wire power_mgmt_regulating;
wire [7:0] status_w;
wire [7:0] fault_live;
wire [7:0] fault_w;
wire thermistor_cold;
wire thermistor_hot;
reg [7:0] misc_r;

assign power_mgmt_regulating = input_voltage_regulation | input_current_regulation;
assign status_w = {input_source_status,
                   charge_phase_status,
                   power_mgmt_regulating,
                   input_good_status,
                   thermal_reg_status,
                   min_sys_reg_status};
assign thermistor_cold = boost_mode ? cold_boost : cold_buck;
assign thermistor_hot = boost_mode ? hot_boost : hot_buck;
assign fault_live = {watchdog_expired, boost_fault, charge_fault_code, battery_overvoltage_fault,
                     1'b0, thermistor_cold, thermistor_hot};

// ==========================================================
// bus states
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_ACK = 3'h2;
localparam [2:0] ST_PTR = 3'h3;
localparam [2:0] ST_WDATA = 3'h4;
localparam [2:0] ST_RDATA = 3'h5;
localparam [2:0] ST_RACK = 3'h6;

reg [2:0] state_r;
reg [2:0] after_ack_r;
reg [3:0] bit_cnt_r;
reg [7:0] shift_r;
reg [7:0] ptr_r;
reg scl_q_r;
reg sda_q_r;
reg mack_r;

wire scl_rise;
wire scl_fall;
wire start_cond;
wire stop_cond;
wire load_now;
wire wr_now;
wire fault_clear;
wire [7:0] rd_data;

assign scl_rise = scl & ~scl_q_r;
assign scl_fall = ~scl & scl_q_r;
assign start_cond = scl & scl_q_r & sda_q_r & ~sda_in;
assign stop_cond = scl & scl_q_r & ~sda_q_r & sda_in;
assign load_now = scl_fall & (((state_r == ST_ACK) & (after_ack_r == ST_RDATA)) |
                              ((state_r == ST_RACK) & mack_r));
assign wr_now = scl_fall & (state_r == ST_WDATA) & (bit_cnt_r == 4'h8);
assign fault_clear = load_now & (ptr_r == `CFR_ADDR_FAULT);
assign rd_data = rd_mux(ptr_r, misc_r, status_w, fault_w);

// ==========================================================
// bus engine
always @(posedge mclk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        state_r <= ST_IDLE;
        after_ack_r <= ST_IDLE;
        bit_cnt_r <= 4'h0;
        shift_r <= 8'h00;
        ptr_r <= 8'h00;
        scl_q_r <= 1'b1;
        sda_q_r <= 1'b1;
        mack_r <= 1'b0;
        sda_out <= 1'b0;
        sda_oe_n <= 1'b1;
    end
    else
    begin
        scl_q_r <= scl;
        sda_q_r <= sda_in;
        if (start_cond)
        begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
        end
        else if (stop_cond)
        begin
            state_r <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end
        else if (scl_rise)
        begin
            case (state_r)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    shift_r <= {shift_r[6:0], sda_in};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                ST_RDATA:
                begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                ST_RACK:
                begin
                    mack_r <= ~sda_in;
                end
                default:
                begin
                    bit_cnt_r <= bit_cnt_r;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (state_r)
                ST_ADDR:
                begin
                    if (bit_cnt_r == 4'h8)
                    begin
                        if (shift_r[7:1] == DEV_ADDR)
                        begin
                            sda_oe_n <= 1'b0;
                            state_r <= ST_ACK;
                            after_ack_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                        end
                        else
                        begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_PTR:
                begin
                    if (bit_cnt_r == 4'h8)
                    begin
                        ptr_r <= shift_r;
                        sda_oe_n <= 1'b0;
                        state_r <= ST_ACK;
                        after_ack_r <= ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (bit_cnt_r == 4'h8)
                    begin
                        ptr_r <= ptr_r + 8'h01;
                        sda_oe_n <= 1'b0;
                        state_r <= ST_ACK;
                        after_ack_r <= ST_WDATA;
                    end
                end
                ST_ACK, ST_RACK:
                begin
                    bit_cnt_r <= 4'h0;
                    if (load_now)
                    begin
                        shift_r <= rd_data;
                        ptr_r <= ptr_r + 8'h01;
                        sda_oe_n <= rd_data[7];
                        state_r <= ST_RDATA;
                    end
                    else if (state_r == ST_ACK)
                    begin
                        sda_oe_n <= 1'b1;
                        state_r <= after_ack_r;
                    end
                    else
                    begin
                        sda_oe_n <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_RDATA:
                begin
                    if (bit_cnt_r == 4'h8)
                    begin
                        sda_oe_n <= 1'b1;
                        state_r <= ST_RACK;
                    end
                    else
                    begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_n <= shift_r[6];
                    end
                end
                default:
                begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end
end

// ==========================================================
// control register
always @(posedge mclk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        misc_r <= `CFR_MISC_RESET;
        port_detect_active <= 1'b0;
        timer_half_speed <= 1'b0;
    end
    else
    begin
        if (wr_now && ptr_r == `CFR_ADDR_MISC)
        begin
            misc_r <= shift_r;
        end
        else if (port_detect_done)
        begin
            misc_r[`CFR_MISC_DETECT] <= 1'b0;
        end
        port_detect_active <= misc_r[`CFR_MISC_DETECT] & input_power_present;
        timer_half_speed <= misc_r[`CFR_MISC_SLOWDOWN] &
                            (power_mgmt_regulating | thermal_reg_status);
    end
end

assign port_detect_request = misc_r[`CFR_MISC_DETECT];
assign battery_switch_off = misc_r[`CFR_MISC_BATOFF];

// ==========================================================
// fault latch
cfr_fault_latch u_fault
(
    .mclk(mclk),
    .rst_n(rst_n_r),
    .fault_live(fault_live),
    .adapter_removed(adapter_removed),
    .fault_clear(fault_clear),
    .chg_int_en(misc_r[`CFR_MISC_CHG_INT]),
    .bat_int_en(misc_r[`CFR_MISC_BAT_INT]),
    .fault_r(fault_w),
    .fault_irq_r(fault_irq)
);

endmodule

/* File: testbench/cfr_ctrl_regs_sva.sv */
`timescale 1ns/1ns
// ==========================================
// port checker
module cfr_ctrl_regs_sva
(
    // clock and reset
    input logic mclk,
    input logic arst_n,
    // host bus
    input logic scl,
    input logic sda_out,
    input logic sda_oe_n,
    // control
    input logic port_detect_request,
    input logic port_detect_active,
    input logic timer_half_speed,
    input logic battery_switch_off,
    input logic input_power_present,
    // live conditions
    input logic input_voltage_regulation,
    input logic input_current_regulation,
    input logic thermal_reg_status,
    input logic watchdog_expired,
    input logic boost_fault,
    input logic [1:0] charge_fault_code,
    input logic battery_overvoltage_fault,
    input logic cold_buck,
    input logic cold_boost,
    input logic hot_buck,
    input logic hot_boost,
    input logic adapter_removed,
    // interrupt
    input logic fault_irq
);
    wire any_flt = watchdog_expired | boost_fault | battery_overvoltage_fault | (|charge_fault_code)
        | cold_buck | cold_boost | hot_buck | hot_boost | adapter_removed;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    a_reset_clean: assert property ($rose(arst_n) |->
        !battery_switch_off && !port_detect_request && sda_oe_n)
        else $error("control outputs not at reset values");
    a_detect_act: assert property (port_detect_active == $past(port_detect_request & input_power_present))
        else $error("detection active does not follow request and input power");
    a_detect_rise: assert property ($rose(port_detect_request) |-> !$past(scl))
        else $error("detection request set outside a host write");
    a_batoff_write: assert property ($changed(battery_switch_off) |-> !$past(scl))
        else $error("battery switch changed outside a host write");
    a_half_cause: assert property (timer_half_speed |->
        $past(input_voltage_regulation | input_current_regulation | thermal_reg_status))
        else $error("timer slowed without regulation");
    a_irq_cause: assert property (fault_irq |-> $past(any_flt))
        else $error("interrupt without a fault in the cycle before");
    a_sda_stable: assert property ($changed(sda_oe_n) |-> !$past(scl))
        else $error("data line changed while clock high");
    a_sda_open: assert property (sda_out == 1'b0)
        else $error("data line driven high");
endmodule

bind cfr_ctrl_regs cfr_ctrl_regs_sva i_cfr_ctrl_regs_sva
(
    .mclk, .arst_n, .scl, .sda_out, .sda_oe_n, .port_detect_request, .port_detect_active,
    .timer_half_speed, .battery_switch_off, .input_power_present, .input_voltage_regulation,
    .input_current_regulation, .thermal_reg_status, .watchdog_expired, .boost_fault,
    .charge_fault_code, .battery_overvoltage_fault, .cold_buck, .cold_boost, .hot_buck,
    .hot_boost, .adapter_removed, .fault_irq
);

/* File: testbench/cfr_i2c_host.sv */
`timescale 1ns/1ns
// ==========================================
// host side of the two-wire register bus
module cfr_i2c_host
#(
    parameter [6:0] DEV = 7'h50
)
(
    // clock
    input wire mclk,
    // bus lines
    input wire sda,
    output reg scl = 1'b1,
    output reg sda_low = 1'b0,
    // results
    output reg [7:0] rd_data = 8'h00,
    output reg rd_valid = 1'b0,
    output reg [7:0] nack_cnt = 8'h00
);
    task bit_io(input b, output q);
    begin
        sda_low <= !b;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        q = sda;
        scl <= 1'b0;
        repeat (2) @(posedge mclk);
    end
    endtask

    task byte_io(input [7:0] d, input a, output [7:0] q, output k);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], q[i]);
        bit_io(a, k);
    end
    endtask

    task start;
    begin
        @(posedge mclk);
        sda_low <= 1'b0;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        sda_low <= 1'b1;
        repeat (2) @(posedge mclk);
        scl <= 1'b0;
        repeat (2) @(posedge mclk);
    end
    endtask

    task stop;
    begin
        sda_low <= 1'b1;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        sda_low <= 1'b0;
        repeat (2) @(posedge mclk);
    end
    endtask

    task wr(input [7:0] p, input [7:0] d, input [6:0] dev);
        reg [7:0] q;
        reg k0, k1, k2;
    begin
        start;
        byte_io({dev, 1'b0}, 1'b1, q, k0);
        byte_io(p, 1'b1, q, k1);
        byte_io(d, 1'b1, q, k2);
        stop;
        nack_cnt <= nack_cnt + k0 + k1 + k2;
    end
    endtask

    task rd(input [7:0] p, output [7:0] d);
        reg [7:0] q;
        reg k0, k1, k2, k3;
    begin
        start;
        byte_io({DEV, 1'b0}, 1'b1, q, k0);
        byte_io(p, 1'b1, q, k1);
        start;
        byte_io({DEV, 1'b1}, 1'b1, q, k2);
        byte_io(8'hff, 1'b1, d, k3);
        stop;
        nack_cnt <= nack_cnt + k0 + k1 + k2;
        rd_data <= d;
        rd_valid <= 1'b1;
        @(posedge mclk);
        rd_valid <= 1'b0;
    end
    endtask
endmodule

/* File: testbench/cfr_ctrl_regs_tb_top.sv */
`timescale 1ns/1ns
// ==========================================
// bench top
module cfr_ctrl_regs_tb_top;
    reg mclk = 1'b0;
    reg arst_n = 1'b0;
    reg ipp = 1'b0;
    reg done = 1'b0;
    reg [8:0] sv = 9'h000;
    reg [10:0] fv = 11'h000;
    reg [7:0] exp_q[$];
    reg [18:0] ftab [0:10];
    reg [7:0] v;
    reg [31:0] r;
    integer i, n0;
    integer irq_n = 0;
    integer mismatches = 0;
    integer tests_run = 0;
    integer seed = 32'ha58cbec5;
    wire scl, sda_low, sda_out, sda_oe_n, pdr, pda, ths, bso, irq, rdv;
    wire [7:0] rdd, nk;
    wire sda = !(sda_low || !sda_oe_n);

    always #20 mclk = ~mclk;

    cfr_ctrl_regs i_cfr_ctrl_regs
    (
        .mclk(mclk), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .port_detect_request(pdr), .port_detect_active(pda), .timer_half_speed(ths),
        .battery_switch_off(bso), .input_power_present(ipp), .port_detect_done(done),
        .input_source_status(sv[8:7]), .charge_phase_status(sv[6:5]), .input_voltage_regulation(sv[4]),
        .input_current_regulation(sv[3]), .input_good_status(sv[2]), .thermal_reg_status(sv[1]),
        .min_sys_reg_status(sv[0]), .watchdog_expired(fv[10]), .boost_fault(fv[9]),
        .battery_overvoltage_fault(fv[8]), .boost_mode(fv[7]), .cold_buck(fv[6]), .cold_boost(fv[5]),
        .hot_buck(fv[4]), .hot_boost(fv[3]), .charge_fault_code(fv[2:1]), .adapter_removed(fv[0]),
        .fault_irq(irq)
    );

    cfr_i2c_host i_cfr_i2c_host
    (
        .mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low), .rd_data(rdd), .rd_valid(rdv), .nack_cnt(nk)
    );

    // ==========================================
    // helpers
    task chk(input string nm, input [7:0] e, input [7:0] s);
    begin
        tests_run = tests_run + 1;
        if (s !== e)
        begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    end
    endtask

    task rdx(input [7:0] p, input [7:0] e);
        reg [7:0] d;
    begin
        exp_q.push_back(e);
        i_cfr_i2c_host.rd(p, d);
    end
    endtask

    task wr(input [7:0] p, input [7:0] d);
        i_cfr_i2c_host.wr(p, d, 7'h50);
    endtask

    task look;
        @(negedge mclk);
    endtask

    task fpulse(input [10:0] f);
    begin
        @(posedge mclk);
        fv <= f;
        @(posedge mclk);
        fv <= 11'h000;
    end
    endtask

    task summarize;
    begin
        $display("counts: %0d compared, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    // ==========================================
    // result watcher
    always @(posedge mclk)
    begin
        if (irq === 1'b1)
            irq_n <= irq_n + 1;
        if (rdv === 1'b1)
            chk("read", exp_q.size() ? exp_q.pop_front() : 8'hxx, rdd);
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        mismatches = mismatches + 1;
        $display("timeout");
        summarize;
    end

    // ==========================================
    // scenarios
    initial
    begin
        ftab[0] = 19'h40080;
        ftab[1] = 19'h20040;
        ftab[2] = 19'h10008;
        ftab[3] = 19'h04002;
        ftab[4] = 19'h09000;
        ftab[5] = 19'h08801;
        ftab[6] = 19'h0a002;
        ftab[7] = 19'h00210;
        ftab[8] = 19'h00420;
        ftab[9] = 19'h00630;
        ftab[10] = 19'h00110;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdx(8'h07, 8'h4b);
        look;
        chk("batoff", 8'h00, bso);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1)
        begin
            r = $random(seed);
            v = {1'h0, i[0], i[1], r[4:0]};
            wr(8'h07, v);
            @(posedge mclk);
            sv <= r[16:8];
            look;
            look;
            chk("halfspd", v[6] & (sv[4] | sv[3] | sv[1]), ths);
            chk("batoff", v[5], bso);
            rdx(8'h07, v);
        end
        $display("test control done");
        @(posedge mclk);
        ipp <= 1'b1;
        wr(8'h07, 8'hcb);
        look;
        chk("detact", 8'h01, pda);
        @(posedge mclk);
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        look;
        chk("detreq", 8'h00, pdr);
        rdx(8'h07, 8'h4b);
        $display("test detection done");
        for (i = 0; i < 4; i = i + 1)
        begin
            r = $random(seed);
            @(posedge mclk);
            sv <= {i[1:0], ~i[1:0], r[4:0]};
            @(posedge mclk);
            v = {sv[8:5], sv[4] | sv[3], sv[2:0]};
            rdx(8'h08, v);
            rdx(8'h08, v);
        end
        $display("test status done");
        for (i = 0; i < 11; i = i + 1)
        begin
            n0 = irq_n;
            fpulse(ftab[i][18:8]);
            rdx(8'h09, ftab[i][7:0]);
            rdx(8'h09, 8'h00);
            chk("irqs", n0 + (ftab[i][7:0] != 8'h00), irq_n);
        end
        $display("test faults done");
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h07, {6'h02, i[1:0]});
            n0 = irq_n;
            fpulse(11'h002);
            fpulse(11'h100);
            rdx(8'h09, 8'h18);
            chk("irqs", n0 + i[0] + i[1], irq_n);
        end
        $display("test masks done");
        i_cfr_i2c_host.wr(8'h07, 8'hff, 7'h51);
        look;
        chk("nacks", 8'h03, nk);
        rdx(8'h07, 8'h0b);
        rdx(8'h0c, 8'h00);
        wr(8'h09, 8'hff);
        rdx(8'h09, 8'h00);
        look;
        chk("queue", 8'h00, exp_q.size());
        $display("test refusals done");
        summarize;
    end
endmodule
